/* File: dbm_cycle_ctrl.sv */
// Bus master cycle sequencer, address-strobe bus style.
// Assumes mclk is the bus clock and the requester holds a request until taken.
// How it works
// RULE1: System holds reset ten slow clocks minimum.
// RULE2: Data strobe only in cycles with waits.
// RULE3: One idle clock between descriptor write, read.
// RULE4: Release data bus after that idle.
// RULE5: Direction output holds across same-kind cycles.
// RULE6: Async ready sampled on falling edge, synchronised.
// RULE7: Async ready seen low ends cycle next.
// RULE8: Ready in T1 gives two clocks; T2 three.
// RULE9: Repeat wait state until ready sampled low.
`timescale 1ns/10ps
`default_nettype none
module dbm_cycle_ctrl #(
	parameter int unsigned ADDR_W = dbm_pkg::ADDR_W_DEF,
	parameter int unsigned DATA_W = dbm_pkg::DATA_W_DEF
) (
	input  wire logic              mclk,
	input  wire logic              rst,
	input  wire logic              async_ready_mode,
	input  wire logic              req_valid,
	output var  logic              req_ready,
	input  wire logic              req_write,
	input  wire logic              req_desc,
	input  wire logic [ADDR_W-1:0] req_addr,
	input  wire logic [DATA_W-1:0] req_wdata,
	output var  logic              done,
	output var  logic [DATA_W-1:0] rd_data,
	output var  logic [ADDR_W-1:0] mem_addr,
	output var  logic              address_strobe_n,
	output var  logic              early_cycle_start_n,
	output var  logic              data_strobe_n,
	output var  logic              write_not_read,
	input  wire logic              memory_ready_in_n,
	output var  logic [DATA_W-1:0] data_out,
	output var  logic              data_oe_n,
	input  wire logic [DATA_W-1:0] data_in
);
	initial begin
		if (ADDR_W < 1 || DATA_W < 1) begin
			$error("dbm_cycle_ctrl: widths must be positive");
		end
	end

	typedef struct packed {
		dbm_pkg::dbm_state_t st;
		logic [ADDR_W-1:0]   addr;
		logic [DATA_W-1:0]   wdata;
		logic [DATA_W-1:0]   rdata;
		logic                wnr;
		logic                pend_wr;
		logic                last_wr_desc;
		logic                as_n;
		logic                ecs_n;
		logic                ds_n;
		logic                oe_n;
		logic                done;
	} dbm_regs_t;

	dbm_regs_t cur_ff;
	dbm_regs_t nxt_cur;
	logic      rdy_sync_n;
	logic      rdy_seen;

	dbm_rdy_sample u_rdy (
		.mclk      (mclk),
		.rst       (rst),
		.rdy_pin_n (memory_ready_in_n),
		.rdy_sync_n(rdy_sync_n)
	);

	// Async ready goes through the sampler; sync ready is already aligned
	assign rdy_seen  = async_ready_mode ? ~rdy_sync_n : ~memory_ready_in_n; // [RULE6] [RULE7]
	assign req_ready = (cur_ff.st == dbm_pkg::DBM_IDLE);

	always_comb begin
		nxt_cur      = cur_ff;
		nxt_cur.done = 1'b0;
		unique case (cur_ff.st)
			dbm_pkg::DBM_IDLE: begin
				if (req_valid) begin
					nxt_cur.addr    = req_addr;
					nxt_cur.pend_wr = req_write;
					if (req_write) begin
						nxt_cur.wdata = req_wdata;
					end
					if (cur_ff.last_wr_desc && req_desc && !req_write) begin
						// Write data stays on the bus through the idle clock
						nxt_cur.st = dbm_pkg::DBM_TI; // [RULE3]
					end else begin
						nxt_cur.st    = dbm_pkg::DBM_T1;
						nxt_cur.as_n  = 1'b0;
						nxt_cur.ecs_n = 1'b0;
						nxt_cur.wnr   = req_write; // [RULE5]
						nxt_cur.oe_n  = ~req_write;
					end
					nxt_cur.last_wr_desc = req_write && req_desc;
				end else begin
					nxt_cur.oe_n = 1'b1;
				end
			end
			dbm_pkg::DBM_TI: begin
				nxt_cur.st    = dbm_pkg::DBM_T1;
				nxt_cur.oe_n  = 1'b1; // [RULE4]
				nxt_cur.as_n  = 1'b0;
				nxt_cur.ecs_n = 1'b0;
				nxt_cur.wnr   = cur_ff.pend_wr; // [RULE5]
			end
			dbm_pkg::DBM_T1: begin
				nxt_cur.st    = dbm_pkg::DBM_T2;
				nxt_cur.as_n  = 1'b1;
				nxt_cur.ecs_n = 1'b1;
			end
			dbm_pkg::DBM_T2: begin
				if (rdy_seen) begin
					nxt_cur.st   = dbm_pkg::DBM_IDLE; // [RULE7] [RULE8]
					nxt_cur.done = 1'b1;
					nxt_cur.ds_n = 1'b1;
					if (!cur_ff.wnr) begin
						nxt_cur.rdata = data_in;
					end
				end else begin
					// Wait state: address, address strobe and direction held; data strobe driven low
					nxt_cur.st   = dbm_pkg::DBM_T2; // [RULE9]
					nxt_cur.ds_n = 1'b0; // [RULE2]
				end
			end
			default: begin
				nxt_cur.st = dbm_pkg::DBM_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cur_ff <= '{st: dbm_pkg::DBM_IDLE, addr: '0, wdata: '0, rdata: '0, wnr: 1'b0,
				pend_wr: 1'b0, last_wr_desc: 1'b0, as_n: 1'b1, ecs_n: 1'b1,
				ds_n: 1'b1, oe_n: 1'b1, done: 1'b0};
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	assign done                = cur_ff.done;
	assign rd_data             = cur_ff.rdata;
	assign mem_addr            = cur_ff.addr;
	assign address_strobe_n    = cur_ff.as_n;
	assign early_cycle_start_n = cur_ff.ecs_n;
	assign data_strobe_n       = cur_ff.ds_n;
	assign write_not_read      = cur_ff.wnr;
	assign data_out            = cur_ff.wdata;
	assign data_oe_n           = cur_ff.oe_n;
endmodule
`default_nettype wire

/* File: dbm_pkg.sv */
// Shared constants and types of the bus master cycle sequencer.
// Assumes a 20 MHz mclk that is also the bus clock.
package dbm_pkg;
	localparam int unsigned ADDR_W_DEF  = 32;
	localparam int unsigned DATA_W_DEF  = 32;
	localparam int unsigned RST_MIN_CLK = 10;

	typedef enum logic [3:0] {
		DBM_IDLE = 4'h1,
		DBM_T1   = 4'h2,
		DBM_T2   = 4'h4,
		DBM_TI   = 4'h8
	} dbm_state_t;
endpackage

/* File: dbm_rdy_sample.sv */
// Ready sampler: falling edge capture, then rising edge re-time.
// Assumes the ready pin is asynchronous to mclk.
`timescale 1ns/10ps
`default_nettype none
module dbm_rdy_sample (
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic rdy_pin_n,
	output var  logic rdy_sync_n
);
	logic fall_ff;

	// First stage on the falling edge, read only by the second stage
	always_ff @(negedge mclk or posedge rst) begin
		if (rst) begin
			fall_ff <= 1'b1;
		end else begin
			fall_ff <= rdy_pin_n;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rdy_sync_n <= 1'b1;
		end else begin
			rdy_sync_n <= fall_ff;
		end
	end
endmodule
`default_nettype wire

/* File: dbm_cycle_asserts.sv */
// Port timing checks of the bus cycle sequencer.
// Bound into dbm_cycle_ctrl; one clock, async reset.
`timescale 1ns/10ps
`default_nettype none
module dbm_cycle_asserts #(parameter int unsigned ADDR_W = 32) (
	input wire logic mclk, rst, async_ready_mode, req_valid, req_ready, req_write,
	input wire logic req_desc, done, address_strobe_n, data_strobe_n, write_not_read,
	input wire logic memory_ready_in_n, data_oe_n, early_cycle_start_n,
	input wire logic [ADDR_W-1:0] mem_addr
);
	logic ld_ff;
	wire tk = req_valid && req_ready;
	wire ti = tk && done && ld_ff && req_desc && !req_write;
	wire ack = !req_ready && !memory_ready_in_n;
	always_ff @(posedge mclk or posedge rst)
		if (rst) ld_ff <= 1'h0;
		else if (tk) ld_ff <= req_desc && req_write;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence zero_wait; !address_strobe_n ##2 done; endsequence
	chk_ds_zero: assert property (zero_wait |-> $past(data_strobe_n))
		else $error("strobe in zero wait");
	chk_ds_t1: assert property (!data_strobe_n |-> address_strobe_n && !req_ready)
		else $error("strobe outside wait");
	chk_ti_gap: assert property (ti |=> address_strobe_n ##1 !address_strobe_n)
		else $error("idle clock missing");
	chk_bus_rel: assert property (ti |=> !data_oe_n ##1 data_oe_n)
		else $error("data bus held");
	chk_wnr_hold: assert property ($changed(write_not_read) |-> !address_strobe_n)
		else $error("direction moved");
	chk_async_end: assert property (async_ready_mode && ack |-> ##2 done)
		else $error("async ready missed");
	chk_sync_end: assert property (!async_ready_mode && address_strobe_n && ack |=> done)
		else $error("sync ready missed");
	chk_t2_hold: assert property (address_strobe_n && !req_ready && !$past(req_ready)
		|-> $stable(mem_addr)) else $error("wait address moved");
	chk_ecs_pair: assert property (early_cycle_start_n == address_strobe_n)
		else $error("early start apart from address strobe");
endmodule
bind dbm_cycle_ctrl dbm_cycle_asserts #(.ADDR_W(ADDR_W)) dbm_cycle_asserts_inst (.*);
`default_nettype wire

/* File: dbm_mem_model.sv */
// Memory side: ready after a set number of waits.
// Ready idles high; data inverts while write_not_read is high.
`timescale 1ns/10ps
`default_nettype none
module dbm_mem_model (
	input wire logic mclk, rst, async_ready_mode, address_strobe_n, done, write_not_read,
	input wire logic [1:0] waits,
	input wire logic [31:0] mem_addr,
	output var logic memory_ready_in_n,
	output var logic [31:0] data_in
);
	logic [3:0] st_ff;
	wire [2:0] k = address_strobe_n ? st_ff[2:0] : 3'h0;
	always_ff @(posedge mclk or posedge rst)
		if (rst) st_ff <= 4'h0;
		else st_ff <= {!address_strobe_n | st_ff[3] & !done, k + 3'h1};
	// Async ready one clock earlier, changing only after rising edges
	assign memory_ready_in_n = !((st_ff[3] | !address_strobe_n)
		&& k == 3'(waits) + 3'(!async_ready_mode));
	assign data_in = {32{write_not_read}} ^ mem_addr ^ 32'h5A5AA5A5;
endmodule
`default_nettype wire

/* File: tb_dma_bus_master_cycle_control.sv */
// Random back-to-back cycles in both ready modes.
// Assumes the memory model and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module tb_dma_bus_master_cycle_control;
	logic mclk = 1'h0, rst = 1'h1, async_ready_mode = 1'h0, req_valid = 1'h0, req_write = 1'h0;
	logic req_desc = 1'h0, req_ready, done, address_strobe_n, early_cycle_start_n, data_strobe_n;
	logic write_not_read, memory_ready_in_n, data_oe_n, lw;
	logic [1:0] waits = 2'h0, w;
	logic [31:0] req_addr = 32'h0, req_wdata = 32'h0, rd_data, mem_addr, data_out, data_in, r;
	logic [64:0] nt, notes[$];
	int cyc = 0, err_total = 0, checked = 0;
	always #25 mclk = ~mclk;
	always @(posedge mclk) cyc <= cyc + 1;
	dbm_cycle_ctrl dbm_cycle_ctrl_inst (.*);
	dbm_mem_model dbm_mem_model_inst (.*);
	task automatic check(input string nm, input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wrap_up;
		if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	always @(negedge mclk) if (done === 1'h1) begin
		nt = notes.pop_front();
		check("done cycle", 32'(cyc), nt[63:32]);
		if (!nt[64]) check("read data", rd_data, nt[31:0]);
		else check("write data", data_out, ~(nt[31:0] ^ 32'h5A5AA5A5));
		check("address", mem_addr, nt[31:0] ^ 32'h5A5AA5A5);
		check("direction", 32'(write_not_read), 32'(nt[64]));
	end
	initial begin
		#200000;
		err_total++;
		wrap_up();
	end
	initial begin
		void'($urandom(32'h0E853A05));
		for (int m = 0; m < 2; m++) begin
			rst <= 1'h1;
			async_ready_mode <= m[0];
			lw = 1'h0;
			repeat (dbm_pkg::RST_MIN_CLK) @(posedge mclk);
			rst <= 1'h0;
			repeat (80) begin
				r = $urandom;
				w = 2'($urandom % 3);
				req_valid <= 1'h1;
				req_write <= r[0];
				req_desc <= r[1];
				req_addr <= ~r;
				req_wdata <= r;
				do @(negedge mclk); while (req_ready !== 1'h1);
				// Descriptor read after descriptor write pays one idle clock
				notes.push_back({r[0], 32'(cyc + 3 + w + (lw & r[1] & !r[0])), ~r ^ 32'h5A5AA5A5});
				lw = r[0] & r[1];
				@(posedge mclk);
				waits <= w;
			end
			req_valid <= 1'h0;
			repeat (12) @(posedge mclk);
		end
		wrap_up();
	end
endmodule
`default_nettype wire
